/* File: logic/acr_pkg.sv */
// register map, field positions, reset values and state codes of the converter control block
// assumes a 32-bit APB master on pclk; every register sits in the low byte of an aligned word
`default_nettype none
package acr_pkg;
   // ----------------------------------------
   // register byte offsets
   // ----------------------------------------
   localparam logic [7:0] OFS_CHANNEL_CONTROL = 8'h00;
   localparam logic [7:0] OFS_TRIGGER_COMPARE = 8'h04;
   localparam logic [7:0] OFS_RESULT_HIGH = 8'h08;
   localparam logic [7:0] OFS_RESULT_LOW = 8'h0C;
   localparam logic [7:0] OFS_COMPARE_HIGH = 8'h10;
   localparam logic [7:0] OFS_COMPARE_LOW = 8'h14;
   localparam logic [7:0] OFS_CONFIGURATION = 8'h18;
   // ----------------------------------------
   // field positions
   // ----------------------------------------
   localparam int CC_COMPLETE_BIT = 7;
   localparam int CC_INT_ENABLE_BIT = 6;
   localparam int CC_CONTINUOUS_BIT = 5;
   localparam int TC_ACTIVE_BIT = 7;
   localparam int TC_TRIGGER_BIT = 6;
   localparam int TC_CMP_ENABLE_BIT = 5;
   localparam int TC_CMP_DIR_BIT = 4;
   // ----------------------------------------
   // codes and reset values
   // ----------------------------------------
   localparam logic [4:0] CHANNEL_DISABLED = 5'h1F;
   localparam logic [1:0] MODE_8BIT = 2'h0;
   localparam logic [1:0] MODE_10BIT = 2'h2;
   localparam logic [1:0] CLK_BUS = 2'h0;
   localparam logic [1:0] CLK_BUS_HALF = 2'h1;
   localparam logic [1:0] CLK_ALT = 2'h2;
   localparam logic [1:0] CLK_ASYNC = 2'h3;
   localparam logic [2:0] DIV_MASK_1 = 3'h0;
   localparam logic [2:0] DIV_MASK_2 = 3'h1;
   localparam logic [2:0] DIV_MASK_4 = 3'h3;
   localparam logic [2:0] DIV_MASK_8 = 3'h7;
   localparam logic [3:0] BITS_8 = 4'h8;
   localparam logic [3:0] BITS_10 = 4'hA;
   localparam logic [7:0] RESET_BYTE = 8'h00;
   localparam logic [1:0] RESET_PAIR = 2'h0;
   localparam logic [4:0] RESET_COUNT = 5'h00;
   localparam logic [31:0] READ_ZERO = 32'h0000_0000;
   // configuration register, laid out msb first as software sees it
   typedef struct packed {
      logic low_power_select;
      logic [1:0] clock_divider_select;
      logic sample_length_select;
      logic [1:0] mode;
      logic [1:0] clock_source_select;
   } acr_cfg_t;
   localparam acr_cfg_t CFG_RESET = '{1'b0, 2'h0, 1'b0, 2'h0, 2'h0};
   typedef enum logic [2:0] {
      ST_IDLE = 3'b001,
      ST_SAMPLE = 3'b010,
      ST_CONVERT = 3'b100
   } acr_state_t;
endpackage : acr_pkg
`default_nettype wire

/* File: logic/acr_adc_control.sv */
// digital control, result and compare logic of a successive-approximation converter
// assumes an APB master on pclk, an external sample switch, trial DAC and comparator;
// the alternate and asynchronous clock inputs are synchronous to pclk and only their rising edges are used
//
// Implementation choices: the APB interface to the registers and the register offsets.
`default_nettype none

module acr_adc_control
   import acr_pkg::*;
#(
   parameter int SAMPLE_SHORT_TICKS = 4,
   parameter int SAMPLE_LONG_TICKS = 20
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic hardware_trigger_input,
   input wire logic alternate_clock_input,
   input wire logic converter_async_clock,
   input wire logic comparator_above,
   output logic [4:0] channel_select,
   output logic [9:0] sar_trial,
   output logic sample_enable,
   output logic converter_powered,
   output logic low_power_select,
   output logic conversion_complete_flag
);

   // ----------------------------------------
   // registers and state
   // ----------------------------------------
   logic [4:0] channel;
   logic int_enable;
   logic continuous;
   logic trigger_select;
   logic compare_enable;
   logic compare_direction;

   logic [1:0] compare_value_high;
   logic [7:0] compare_value_low;
   acr_cfg_t cfg;
   logic [7:0] result_low;
   logic [1:0] result_high;
   logic interlock;
   logic complete;

   acr_state_t state;
   logic [4:0] tick_count;
   logic [3:0] bit_index;
   logic [9:0] sar_acc;

   logic [2:0] div_count;
   logic half_phase;
   logic alt_prev;
   logic async_prev;
   logic trig_meta;
   logic trig_sync;
   logic trig_prev;
   logic [31:0] read_data;

   // ----------------------------------------
   // bus decode
   // ----------------------------------------
   wire setup_phase = psel & ~penable;
   wire access_phase = psel & penable;
   wire wr = access_phase & pwrite;
   wire rd = access_phase & ~pwrite;
   wire [7:0] addr = paddr[7:0];
   wire addr_high_zero = (paddr[31:8] == 24'h000000);
   wire hit_cc = addr_high_zero & (addr == OFS_CHANNEL_CONTROL);
   wire hit_tc = addr_high_zero & (addr == OFS_TRIGGER_COMPARE);
   wire hit_rh = addr_high_zero & (addr == OFS_RESULT_HIGH);
   wire hit_rl = addr_high_zero & (addr == OFS_RESULT_LOW);
   wire hit_ch = addr_high_zero & (addr == OFS_COMPARE_HIGH);
   wire hit_cl = addr_high_zero & (addr == OFS_COMPARE_LOW);
   wire hit_cfg = addr_high_zero & (addr == OFS_CONFIGURATION);
   wire mapped = hit_cc | hit_tc | hit_rh | hit_rl | hit_ch | hit_cl | hit_cfg;
   wire wr_cc = wr & hit_cc;
   wire wr_tc = wr & hit_tc;
   wire wr_cfg = wr & hit_cfg;
   wire rd_rh = rd & hit_rh;
   wire rd_rl = rd & hit_rl;
   wire acr_cfg_t wr_cfg_value = acr_cfg_t'(pwdata[7:0]);
   wire is_10bit = (cfg.mode == MODE_10BIT);
   wire disabled = (channel == CHANNEL_DISABLED);
   wire new_disabled = (pwdata[4:0] == CHANNEL_DISABLED);
   wire mode_change = wr_cfg & (wr_cfg_value.mode != cfg.mode);

   // ----------------------------------------
   // conversion clock enable
   // ----------------------------------------
   // all sources become one-cycle enables on pclk, so the engine never crosses a clock domain
   wire alt_edge = alternate_clock_input & ~alt_prev;
   wire async_edge = converter_async_clock & ~async_prev;
   wire src_tick = (cfg.clock_source_select == CLK_BUS) ? 1'b1 :
                   (cfg.clock_source_select == CLK_BUS_HALF) ? half_phase :
                   (cfg.clock_source_select == CLK_ALT) ? alt_edge :
                   async_edge;
   wire [2:0] div_mask = (cfg.clock_divider_select == 2'h0) ? DIV_MASK_1 :
                         (cfg.clock_divider_select == 2'h1) ? DIV_MASK_2 :
                         (cfg.clock_divider_select == 2'h2) ? DIV_MASK_4 :
                         DIV_MASK_8;
   wire conv_tick = src_tick & (div_count == div_mask);

   // ----------------------------------------
   // start, abort and completion
   // ----------------------------------------
   wire trig_edge = trig_sync & ~trig_prev;
   // edges that arrive while busy are dropped, not queued
   wire hw_start = trigger_select & trig_edge & ~disabled & (state == ST_IDLE);
   wire sw_start = wr_cc & ~new_disabled & ~trigger_select;
   wire [4:0] sample_ticks = cfg.sample_length_select ? 5'(SAMPLE_LONG_TICKS)
                                                      : 5'(SAMPLE_SHORT_TICKS);
   wire [3:0] last_bit = is_10bit ? (BITS_10 - 4'h1) : (BITS_8 - 4'h1);
   wire [9:0] trial_bit = 10'(1) << bit_index;
   wire [9:0] decided = comparator_above ? (sar_acc | trial_bit) : sar_acc;
   wire finish = (state == ST_CONVERT) & conv_tick & (bit_index == 4'h0) & ~wr_cc;
   // only a software-started run repeats; a hardware start gives one result per edge
   wire restart = finish & continuous & ~disabled & ~trigger_select;

   // ----------------------------------------
   // compare and result transfer
   // ----------------------------------------
   wire [9:0] cmp_value = is_10bit ? {compare_value_high, compare_value_low}
                                   : {2'h0, compare_value_low};
   // in 8-bit mode the upper result bits never take part in the compare
   wire [9:0] cmp_result = is_10bit ? decided : {2'h0, decided[7:0]};
   wire cmp_true = compare_direction ? (cmp_result >= cmp_value)
                                     : (cmp_result < cmp_value);
   wire accept = ~compare_enable | cmp_true;
   // a result finished while blocked is lost, yet complete still rises
   wire blocked = is_10bit & interlock;
   wire load_result = finish & accept & ~blocked;
   wire set_complete = finish & accept;
   wire clear_complete = wr_cc | rd_rl;

   // ----------------------------------------
   // read mux
   // ----------------------------------------
   wire [7:0] cc_read = {complete, int_enable, continuous, channel};
   wire [7:0] tc_read = {(state != ST_IDLE), trigger_select, compare_enable,
                         compare_direction, 4'h0};
   wire [7:0] rh_read = is_10bit ? {6'h00, result_high} : RESET_BYTE;
   wire [7:0] read_byte = hit_cc ? cc_read :
                          hit_tc ? tc_read :
                          hit_rh ? rh_read :
                          hit_rl ? result_low :
                          hit_ch ? {6'h00, compare_value_high} :
                          hit_cl ? compare_value_low :
                          hit_cfg ? cfg :
                          RESET_BYTE;
   // every register answers in its access cycle, so no wait states
   assign pready = 1'b1;
   assign pslverr = access_phase & ~mapped;
   assign prdata = read_data;
   assign channel_select = channel;
   // the trial word keeps the last result while idle; the comparator is ignored then
   assign sar_trial = sar_acc | trial_bit & {10{state == ST_CONVERT}};
   assign sample_enable = (state == ST_SAMPLE);
   assign converter_powered = (state != ST_IDLE);
   assign low_power_select = cfg.low_power_select;
   assign conversion_complete_flag = complete;

   // ----------------------------------------
   // bus read data
   // ----------------------------------------
   // captured in the setup cycle so prdata comes from a flop and no wait state is needed
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         read_data <= READ_ZERO;
      end else if (setup_phase & ~pwrite) begin
         read_data <= {24'h000000, read_byte};
      end
   end

   // ----------------------------------------
   // software registers
   // ----------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         channel <= CHANNEL_DISABLED;
         int_enable <= 1'b0;
         continuous <= 1'b0;
      end else if (wr_cc) begin
         channel <= pwdata[4:0];
         int_enable <= pwdata[CC_INT_ENABLE_BIT];
         continuous <= pwdata[CC_CONTINUOUS_BIT];
      end
   end

   // bits 3 to 0 are not stored, so a nonzero write there has no effect
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         trigger_select <= 1'b0;
         compare_enable <= 1'b0;
         compare_direction <= 1'b0;
      end else if (wr_tc) begin
         trigger_select <= pwdata[TC_TRIGGER_BIT];
         compare_enable <= pwdata[TC_CMP_ENABLE_BIT];
         compare_direction <= pwdata[TC_CMP_DIR_BIT];
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         compare_value_high <= RESET_PAIR;
         compare_value_low <= RESET_BYTE;
      end else if (wr & hit_ch) begin
         compare_value_high <= pwdata[1:0];
      end else if (wr & hit_cl) begin
         compare_value_low <= pwdata[7:0];
      end
   end

   // reserved mode codes are stored but run as 8-bit, since only 10 selects 10-bit
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cfg <= CFG_RESET;
      end else if (wr_cfg) begin
         cfg <= wr_cfg_value;
      end
   end

   // ----------------------------------------
   // results, interlock and complete flag
   // ----------------------------------------
   // a mode change zeroes the results so stale data never looks valid
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         result_low <= RESET_BYTE;
         result_high <= RESET_PAIR;
      end else if (mode_change) begin
         result_low <= RESET_BYTE;
         result_high <= RESET_PAIR;
      end else if (load_result) begin
         result_low <= decided[7:0];
         result_high <= is_10bit ? decided[9:8] : RESET_PAIR;
      end
   end

   // reading result_low releases; a high read in the same cycle cannot occur on APB
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         interlock <= 1'b0;
      end else if (mode_change | rd_rl) begin
         interlock <= 1'b0;
      end else if (rd_rh & is_10bit) begin
         interlock <= 1'b1;
      end
   end

   // set wins over clear when both land in one cycle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         complete <= 1'b0;
      end else begin
         complete <= set_complete | (complete & ~clear_complete);
      end
   end

   // ----------------------------------------
   // clock divider and edge history
   // ----------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         half_phase <= 1'b0;
         alt_prev <= 1'b0;
         async_prev <= 1'b0;
         div_count <= 3'h0;
      end else begin
         half_phase <= ~half_phase;
         alt_prev <= alternate_clock_input;
         async_prev <= converter_async_clock;
         if (wr_cfg | (conv_tick)) begin
            div_count <= 3'h0;
         end else if (src_tick) begin
            div_count <= div_count + 3'h1;
         end
      end
   end

   // ----------------------------------------
   // hardware trigger synchroniser
   // ----------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         trig_meta <= 1'b0;
         trig_sync <= 1'b0;
         trig_prev <= 1'b0;
      end else begin
         trig_meta <= hardware_trigger_input;
         trig_sync <= trig_meta;
         trig_prev <= trig_sync;
      end
   end

   // ----------------------------------------
   // conversion sequencer
   // ----------------------------------------
   // a channel control write aborts first; a hardware edge in that cycle is dropped
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state <= ST_IDLE;
         tick_count <= RESET_COUNT;
         bit_index <= 4'h0;
         sar_acc <= 10'h000;
      end else if (wr_cc) begin
         state <= sw_start ? ST_SAMPLE : ST_IDLE;
         tick_count <= RESET_COUNT;
      end else begin
         case (state)
            ST_IDLE: begin
               if (hw_start) begin
                  state <= ST_SAMPLE;
                  tick_count <= RESET_COUNT;
               end
            end
            ST_SAMPLE: begin
               if (conv_tick) begin
                  if (tick_count + 5'h01 >= sample_ticks) begin
                     state <= ST_CONVERT;
                     bit_index <= last_bit;
                     sar_acc <= 10'h000;
                  end else begin
                     tick_count <= tick_count + 5'h01;
                  end
               end
            end
            ST_CONVERT: begin
               if (conv_tick) begin
                  sar_acc <= decided;
                  if (bit_index == 4'h0) begin
                     state <= restart ? ST_SAMPLE : ST_IDLE;
                     tick_count <= RESET_COUNT;
                  end else begin
                     bit_index <= bit_index - 4'h1;
                  end
               end
            end
            default: begin
               state <= ST_IDLE;
            end
         endcase
      end
   end
endmodule : acr_adc_control
`default_nettype wire

/* File: dv/acr_adc_chk.sv */
// port checks for the converter control block, bound to it
// assumes continuous conversion stays off, so each completion ends a conversion
`default_nettype none
module acr_adc_chk
   import acr_pkg::*;
#(
   parameter int SAMPLE_SHORT_TICKS = 4,
   parameter int SAMPLE_LONG_TICKS = 20
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic pready,
   input wire logic hardware_trigger_input,
   input wire logic [4:0] channel_select,
   input wire logic sample_enable,
   input wire logic converter_powered,
   input wire logic conversion_complete_flag
);
   timeunit 1ns;
   timeprecision 100ps;
   // ----------------------------------------
   // decode and shadow state
   // ----------------------------------------
   wire logic acc = psel && penable && pready;
   wire logic wr_cc = acc && pwrite && paddr == {24'h0, OFS_CHANNEL_CONTROL};
   wire logic wr_tc = acc && pwrite && paddr == {24'h0, OFS_TRIGGER_COMPARE};
   wire logic rd_rl = acc && !pwrite && paddr == {24'h0, OFS_RESULT_LOW};
   wire logic start_ok = pwdata[4:0] != CHANNEL_DISABLED;
   logic tsel;
   // eight bits: a long sample at the slowest divider of the bus clock still fits without wrapping
   logic [7:0] samp_cnt;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tsel <= 1'b0;
      end else if (wr_tc) begin
         tsel <= pwdata[TC_TRIGGER_BIT];
      end
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         samp_cnt <= 8'h00;
      end else begin
         samp_cnt <= sample_enable ? samp_cnt + 8'h01 : 8'h00;
      end
   end
   // ----------------------------------------
   // assertions
   // ----------------------------------------
   default clocking dc @(posedge pclk);
   endclocking
   default disable iff (!presetn);
   a_sw_start: assert property (wr_cc && !tsel && start_ok |=> converter_powered && sample_enable)
      else $error("software start missed");
   a_disable_stop: assert property (wr_cc && !start_ok |=> !converter_powered && channel_select == 5'h1F)
      else $error("disable did not stop");
   a_hw_write_idle: assert property (wr_cc && tsel |=> !converter_powered)
      else $error("write started under hardware trigger");
   a_hw_edge_start: assert property (tsel && !converter_powered && $rose(hardware_trigger_input)
      && channel_select != CHANNEL_DISABLED |-> ##[1:6] converter_powered)
      else $error("hardware trigger missed");
   a_flag_clr_write: assert property (wr_cc |=> !conversion_complete_flag)
      else $error("flag kept after write");
   a_flag_clr_read: assert property (rd_rl && !converter_powered |=> !conversion_complete_flag)
      else $error("flag kept after result read");
   a_flag_at_end: assert property ($rose(conversion_complete_flag) |-> $past(converter_powered) && !converter_powered)
      else $error("flag set outside completion");
   a_sample_len: assert property ($fell(sample_enable) && converter_powered |-> samp_cnt >= SAMPLE_SHORT_TICKS)
      else $error("sample phase too short");
   a_active_min: assert property ($rose(converter_powered) |-> converter_powered [*8])
      else $error("conversion ended too soon");
endmodule : acr_adc_chk
bind acr_adc_control acr_adc_chk #(.SAMPLE_SHORT_TICKS(SAMPLE_SHORT_TICKS), .SAMPLE_LONG_TICKS(SAMPLE_LONG_TICKS))
   i_acr_adc_chk (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
   .paddr(paddr), .pwdata(pwdata), .pready(pready), .hardware_trigger_input(hardware_trigger_input),
   .channel_select(channel_select), .sample_enable(sample_enable), .converter_powered(converter_powered),
   .conversion_complete_flag(conversion_complete_flag));
`default_nettype wire

/* File: dv/acr_adc_analog.sv */
// sample-and-hold and comparator in place of the analog converter core
// assumes the bench sets the input level before a conversion starts
`default_nettype none
module acr_adc_analog
   import acr_pkg::*;
(
   input wire logic pclk,
   input wire logic [9:0] level,
   input wire logic sample_enable,
   input wire logic converter_powered,
   input wire logic [9:0] sar_trial,
   output logic comparator_above
);
   timeunit 1ns;
   timeprecision 100ps;
   logic [9:0] held;
   logic junk = 1'b0;
   // an unpowered comparator is meaningless, so it toggles instead of settling
   always_ff @(posedge pclk) begin
      if (sample_enable) begin
         held <= level;
      end
      junk <= ~junk;
   end
   assign comparator_above = converter_powered ? held >= sar_trial : junk;
endmodule : acr_adc_analog
`default_nettype wire

/* File: dv/testbench.sv */
// self-checking bench: APB tasks drive the control block, an analog model answers trials
// assumes the register map of acr_pkg and the alternate clocks as pclk-sampled pulses
`default_nettype none
module testbench
   import acr_pkg::*;
;
   timeunit 1ns;
   timeprecision 100ps;
   localparam int SS = 4;
   localparam int SL = 20;
   logic pclk;
   logic presetn = 1'b0;
   logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [31:0] paddr = 32'h0, pwdata = 32'h0;
   logic hardware_trigger_input = 1'b0, alternate_clock_input = 1'b0, converter_async_clock = 1'b0;
   logic [9:0] level = 10'h000;
   logic [31:0] prdata, rdv;
   logic pready, pslverr, last_err, comparator_above, sample_enable, converter_powered;
   logic low_power_select, conversion_complete_flag;
   logic [4:0] channel_select;
   logic [9:0] sar_trial;
   logic [7:0] prev;
   int err_count = 0, n_checks = 0, cycles = 0, tick = 0, cyc;
   logic [7:0] cfgs [10] = '{8'h00, 8'h20, 8'h40, 8'h60, 8'h01, 8'h02, 8'h03, 8'h10, 8'h88, 8'h04};
   int nom [10] = '{SS + 8, 2 * (SS + 8), 4 * (SS + 8), 8 * (SS + 8), 2 * (SS + 8), 3 * (SS + 8),
      4 * (SS + 8), SL + 8, SS + 10, SS + 8};
   logic [7:0] tcs [8] = '{8'h00, 8'h20, 8'h20, 8'h30, 8'h30, 8'h20, 8'h20, 8'h30};
   logic [9:0] cvs [8] = '{10'h080, 10'h080, 10'h080, 10'h080, 10'h080, 10'h100, 10'h100, 10'h100};
   logic [9:0] lvs [8] = '{10'h090, 10'h090, 10'h070, 10'h070, 10'h080, 10'h0FF, 10'h0FF, 10'h0FF};
   logic [7:0] lds = 8'h55;
   acr_adc_control #(.SAMPLE_SHORT_TICKS(SS), .SAMPLE_LONG_TICKS(SL)) i_acr_adc_control (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .hardware_trigger_input(hardware_trigger_input), .alternate_clock_input(alternate_clock_input),
      .converter_async_clock(converter_async_clock), .comparator_above(comparator_above),
      .channel_select(channel_select), .sar_trial(sar_trial), .sample_enable(sample_enable),
      .converter_powered(converter_powered), .low_power_select(low_power_select),
      .conversion_complete_flag(conversion_complete_flag));
   acr_adc_analog i_acr_adc_analog (.pclk(pclk), .level(level), .sample_enable(sample_enable),
      .converter_powered(converter_powered), .sar_trial(sar_trial), .comparator_above(comparator_above));
   // ----------------------------------------
   // clocks, source pulses and timeout
   // ----------------------------------------
   initial begin
      pclk = 1'b0;
      forever #12.5 pclk = ~pclk;
   end
   // alternate source ticks every third cycle, asynchronous one every fourth
   always @(posedge pclk) begin
      tick <= tick + 1;
      alternate_clock_input <= tick % 3 == 0;
      converter_async_clock <= tick % 4 == 0;
   end
   always @(posedge pclk) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         err_count++;
         results();
      end
   end
   // ----------------------------------------
   // tasks
   // ----------------------------------------
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         err_count++;
         $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : check
   task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] wd);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= {24'h0, a};
      pwdata <= {24'h0, wd};
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1) @(posedge pclk);
      rdv = prdata;
      last_err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      apb(1'b1, a, d);
   endtask : wr
   task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
      apb(1'b0, a, 8'h00);
      check(rdv, exp);
   endtask : rdc
   task automatic conv(input logic [4:0] ch);
      wr(OFS_CHANNEL_CONTROL, {3'h0, ch});
      cyc = 0;
      do begin
         @(posedge pclk);
         cyc++;
      end while ((converter_powered !== 1'b0 || cyc < 2) && cyc < 400);
      check(32'(converter_powered), 32'h0);
   endtask : conv
   task automatic results();
      $display("checks %0d mismatches %0d", n_checks, err_count);
      if (err_count == 0 && n_checks > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask : results
   // ----------------------------------------
   // tests
   // ----------------------------------------
   initial begin
      repeat (12) @(posedge pclk);
      presetn <= 1'b1;
      for (int i = 0; i < 7; i++) begin
         rdc(8'(4 * i), i == 0 ? 32'h1F : 32'h0);
      end
      rdc(8'h1C, 32'h0);
      check(32'(last_err), 32'h1);
      $display("test reset done");
      for (int i = 0; i < 10; i++) begin
         level <= cfgs[i][3] ? 10'h2A5 : 10'h0A5;
         wr(OFS_CONFIGURATION, cfgs[i]);
         rdc(OFS_CONFIGURATION, {24'h0, cfgs[i]});
         conv(5'h03);
         check(32'(cyc >= nom[i] - 8 && cyc <= nom[i] + 12), 32'h1);
         check(32'(low_power_select), 32'(cfgs[i][7]));
         rdc(OFS_RESULT_HIGH, cfgs[i][3] ? 32'h2 : 32'h0);
         rdc(OFS_RESULT_LOW, 32'hA5);
      end
      $display("test clocking done");
      for (int m = 0; m < 2; m++) begin
         wr(OFS_CONFIGURATION, m ? 8'h08 : 8'h00);
         rdc(OFS_RESULT_LOW, 32'h0);
         level <= m ? 10'h111 : 10'h011;
         conv(5'h03);
         rdc(OFS_RESULT_HIGH, m ? 32'h1 : 32'h0);
         level <= m ? 10'h222 : 10'h022;
         conv(5'h03);
         rdc(OFS_RESULT_LOW, m ? 32'h11 : 32'h22);
         conv(5'h03);
         rdc(OFS_RESULT_LOW, 32'h22);
      end
      $display("test interlock done");
      for (int k = 0; k < 8; k++) begin
         if (k == 0 || k == 6) begin
            wr(OFS_CONFIGURATION, k == 0 ? 8'h00 : 8'h08);
            prev = 8'h00;
         end
         wr(OFS_TRIGGER_COMPARE, tcs[k]);
         wr(OFS_COMPARE_HIGH, {6'h0, cvs[k][9:8]});
         wr(OFS_COMPARE_LOW, cvs[k][7:0]);
         rdc(OFS_COMPARE_HIGH, {30'h0, cvs[k][9:8]});
         level <= lvs[k];
         conv(5'h05);
         if (lds[k]) begin
            prev = lvs[k][7:0];
         end
         rdc(OFS_CHANNEL_CONTROL, {24'h0, lds[k], 7'h05});
         rdc(OFS_RESULT_LOW, {24'h0, prev});
      end
      $display("test compare done");
      wr(OFS_TRIGGER_COMPARE, 8'h40);
      rdc(OFS_TRIGGER_COMPARE, 32'h40);
      wr(OFS_CHANNEL_CONTROL, 8'h03);
      repeat (4) @(posedge pclk);
      check(32'(converter_powered), 32'h0);
      level <= 10'h03C;
      hardware_trigger_input <= 1'b1;
      repeat (6) @(posedge pclk);
      check(32'(converter_powered), 32'h1);
      repeat (60) @(posedge pclk);
      check(32'(converter_powered), 32'h0);
      hardware_trigger_input <= 1'b0;
      rdc(OFS_RESULT_LOW, 32'h3C);
      $display("test hardware trigger done");
      wr(OFS_TRIGGER_COMPARE, 8'h00);
      wr(OFS_CONFIGURATION, 8'h68);
      level <= 10'h3FF;
      wr(OFS_CHANNEL_CONTROL, 8'h03);
      repeat (8) @(posedge pclk);
      rdc(OFS_TRIGGER_COMPARE, 32'h80);
      wr(OFS_CHANNEL_CONTROL, 8'h1F);
      rdc(OFS_TRIGGER_COMPARE, 32'h00);
      check(32'(channel_select), 32'h1F);
      rdc(OFS_CHANNEL_CONTROL, 32'h1F);
      rdc(OFS_RESULT_LOW, 32'h3C);
      $display("test abort done");
      results();
   end
endmodule : testbench
`default_nettype wire
